// *** hdl/spicc_top.sv ***
// Serial peripheral block: control registers, master/slave shifter, pin muxing, interrupts
// How it works
// RQ1: Receive/fault interrupt enable requests on flags
// RQ2: Disable halts transfer, clears buffers, flags
// RQ3: Transmit-empty interrupt enable requests on flag
// RQ4: Role bit chooses slave or master
// RQ5: Polarity bit inverts serial clock
// RQ6: Phase bit sets first edge timing
// RQ7: Bit order picks MSB or LSB first
// RQ8: Master select pin: GPIO, fault input, output
// RQ9: Slave select pin always select input
// RQ10: Software avoids disable with phase change
// RQ11: Unimplemented option bits read zero
// RQ12: Bidir output enable drives shared pin
// RQ13: Single-wire bit chooses shared data pin
// RQ14: Wait-stop bit halts clocks in wait
// RQ15: Disabled pins return to port control
// RQ16: Master clock from prescaler and divider
// RQ17: Low fault input sets mode fault
// RQ18: Control registers readable and writable always
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module spicc_top
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire spicc_pkg::spicc_bus_t   bus,
  output logic [7:0]                   rdata,
  input  wire logic                    waitMode,
  input  wire spicc_pkg::spicc_pins_in_t pins,
  output logic                         clkOut,
  output logic                         clkOe_n,
  output logic                         mosiOut,
  output logic                         mosiOe_n,
  output logic                         misoOut,
  output logic                         misoOe_n,
  output logic                         selectOut,
  output logic                         selectOe_n,
  output logic                         pinsOwned,
  output logic                         irq
);
  typedef struct packed {
    logic [7:0]                mainCtl;
    logic [7:0]                optCtl;
    logic [7:0]                baud;
    logic [7:0]                txBuf;
    logic                      txFull;
    logic [7:0]                rxBuf;
    logic                      rxFull;
    logic                      txEmpty;
    logic                      modeFault;
    logic                      statusSeen;
    logic                      rxArmed;
    logic [7:0]                shifter;
    logic [3:0]                bitCnt;
    logic                      edgeSel;
    spicc_pkg::spicc_state_t   state;
    logic [2:0]                irqEn;
    logic [2:0]                irqSt;
    logic [7:0]                rdata;
    logic [2:0]                clkSync;
    logic [1:0]                mosiSync;
    logic [1:0]                misoSync;
    logic [2:0]                selSync;
    logic                      clkOut;
    logic                      clkOe_n;
    logic                      mosiOut;
    logic                      mosiOe_n;
    logic                      misoOut;
    logic                      misoOe_n;
    logic                      selectOut;
    logic                      selectOe_n;
    logic                      pinsOwned;
    logic                      irq;
  } spicc_state_all_t;

  spicc_state_all_t s_reg;
  spicc_state_all_t s_next;
  logic             halfTick;

  wire logic enable   = s_reg.mainCtl[spicc_pkg::SYSTEM_ENABLE_POS];
  wire logic master   = s_reg.mainCtl[spicc_pkg::ROLE_SELECT_POS];
  wire logic clock_polarity     = s_reg.mainCtl[spicc_pkg::CLOCK_POLARITY_POS];
  wire logic clock_phase     = s_reg.mainCtl[spicc_pkg::CLOCK_PHASE_POS];
  wire logic lsbFirst = s_reg.mainCtl[spicc_pkg::BIT_ORDER_POS];
  wire logic select_output_enable     = s_reg.mainCtl[spicc_pkg::SELECT_OUT_EN_POS];
  wire logic mode_fault_enable   = s_reg.optCtl[spicc_pkg::MODE_FAULT_EN_POS];
  wire logic bidir_output_enable  = s_reg.optCtl[spicc_pkg::BIDIR_OUT_EN_POS];
  wire logic single   = s_reg.optCtl[spicc_pkg::SINGLE_WIRE_POS];
  wire logic stopped  = waitMode & s_reg.optCtl[spicc_pkg::WAIT_CLOCK_STOP_POS]; // RQ14

  spicc_baud_gen u_baud
  (
    .clk         (clk),
    .rst         (rst),
    .run         (enable & master & ~stopped & (s_reg.state != spicc_pkg::IDLE)),
    .prescaleSel (s_reg.baud[6:4]),
    .divideSel   (s_reg.baud[2:0]),
    .halfTick    (halfTick)
  );

  // Bit taken from shifter edge according to order
  function automatic logic outBit(input logic [7:0] sh, input logic lsb);
    outBit = lsb ? sh[0] : sh[7]; // RQ7
  endfunction : outBit

  function automatic logic [7:0] shiftIn(input logic [7:0] sh, input logic lsb, input logic b);
    shiftIn = lsb ? {b, sh[7:1]} : {sh[6:0], b}; // RQ7
  endfunction : shiftIn

  always_comb
  begin
    logic inBit;
    logic sckRise;
    logic sckFall;
    logic sampleEdge;
    logic shiftEdge;
    logic selLow;
    logic faultNow;
    logic rxDone;
    logic txLoad;
    logic [2:0] events;
    inBit      = 1'b0;
    sckRise    = 1'b0;
    sckFall    = 1'b0;
    sampleEdge = 1'b0;
    shiftEdge  = 1'b0;
    faultNow   = 1'b0;
    rxDone     = 1'b0;
    txLoad     = 1'b0;
    s_next     = s_reg;

    s_next.clkSync  = {s_reg.clkSync[1:0], pins.clkIn};
    s_next.mosiSync = {s_reg.mosiSync[0], pins.mosiIn};
    s_next.misoSync = {s_reg.misoSync[0], pins.misoIn};
    s_next.selSync  = {s_reg.selSync[1:0], pins.selectIn};
    selLow = ~s_reg.selSync[1];

    // Input data line per role and wire mode
    if (master)
    begin
      inBit = single ? s_reg.mosiSync[1] : s_reg.misoSync[1]; // RQ13
    end
    else
    begin
      inBit = single ? s_reg.misoSync[1] : s_reg.mosiSync[1]; // RQ13
    end

    // Bus reads: data word appears in the cycle after the strobe
    s_next.rdata = 8'h00;
    if (s_reg.rxArmed)
    begin
      s_next.rxFull  = 1'b0;
      s_next.rxArmed = 1'b0;
    end
    if (bus.rd)
    begin
      unique case (bus.addr)
        spicc_pkg::MAIN_ADDR:    s_next.rdata = s_reg.mainCtl; // RQ18
        spicc_pkg::OPTION_ADDR:  s_next.rdata = s_reg.optCtl & spicc_pkg::OPTION_MASK; // RQ11
        spicc_pkg::BAUD_ADDR:    s_next.rdata = s_reg.baud;
        spicc_pkg::STATUS_ADDR:
        begin
          s_next.rdata = {s_reg.rxFull, 1'b0, s_reg.txEmpty, s_reg.modeFault, 4'h0};
          s_next.statusSeen = 1'b1;
        end
        spicc_pkg::DATA_ADDR:
        begin
          s_next.rdata = s_reg.rxBuf;
          s_next.rxArmed = s_reg.statusSeen & s_reg.rxFull;
        end
        spicc_pkg::IRQ_EN_ADDR:  s_next.rdata = {5'h00, s_reg.irqEn};
        spicc_pkg::IRQ_ST_ADDR:  s_next.rdata = {5'h00, s_reg.irqSt};
        default:                 s_next.rdata = 8'h00;
      endcase
    end

    if (bus.wr)
    begin
      unique case (bus.addr)
        spicc_pkg::MAIN_ADDR:    s_next.mainCtl = bus.wdata; // RQ18
        spicc_pkg::OPTION_ADDR:  s_next.optCtl = bus.wdata & spicc_pkg::OPTION_MASK; // RQ11
        spicc_pkg::BAUD_ADDR:    s_next.baud = bus.wdata & spicc_pkg::BAUD_MASK;
        spicc_pkg::DATA_ADDR:
        begin
          // Write without a prior status read is dropped
          if (s_reg.statusSeen & s_reg.txEmpty & enable)
          begin
            s_next.txBuf   = bus.wdata;
            s_next.txFull  = 1'b1;
            s_next.txEmpty = 1'b0;
          end
        end
        spicc_pkg::IRQ_EN_ADDR:  s_next.irqEn = bus.wdata[2:0];
        spicc_pkg::IRQ_CLR_ADDR: s_next.irqSt = s_reg.irqSt & ~bus.wdata[2:0];
        default:                 s_next.irqEn = s_reg.irqEn;
      endcase
    end

    // Serial engine, frozen when clocks are stopped in wait
    if (!stopped)
    begin
      if (master)
      begin
        sckRise = 1'b0;
        if (s_reg.state == spicc_pkg::IDLE && s_reg.txFull && enable)
        begin
          s_next.shifter = s_reg.txBuf;
          s_next.txFull  = 1'b0;
          s_next.txEmpty = 1'b1;
          txLoad         = 1'b1;
          s_next.bitCnt  = 4'h0;
          s_next.edgeSel = clock_phase; // RQ6
          s_next.state   = spicc_pkg::LEAD;
        end
        else if (halfTick && s_reg.state != spicc_pkg::IDLE)
        begin
          s_next.edgeSel = ~s_reg.edgeSel;
          if (s_reg.state == spicc_pkg::LEAD)
          begin
            s_next.state = spicc_pkg::SHIFT;
            if (clock_phase)
            begin
              shiftEdge = 1'b1;
            end
            else
            begin
              sampleEdge = 1'b1;
            end
          end
          else if (s_reg.state == spicc_pkg::SHIFT)
          begin
            // Edge that drives the clock active in phase 0, idle in phase 1
            sampleEdge = ~s_reg.edgeSel; // RQ6
            shiftEdge  = s_reg.edgeSel;
          end
          else
          begin
            s_next.state = spicc_pkg::IDLE;
          end
        end
      end
      else if (enable && selLow)
      begin
        // RQ9
        sckRise = s_reg.clkSync[1] & ~s_reg.clkSync[2];
        sckFall = ~s_reg.clkSync[1] & s_reg.clkSync[2];
        if (s_reg.state == spicc_pkg::IDLE)
        begin
          s_next.shifter = s_reg.txFull ? s_reg.txBuf : s_reg.shifter;
          txLoad         = s_reg.txFull;
          s_next.bitCnt  = 4'h0;
          s_next.state   = spicc_pkg::SHIFT;
        end
        else
        begin
          // Leading edge samples when phase is 0, trailing edge when 1
          sampleEdge = ((sckRise & ~clock_polarity) | (sckFall & clock_polarity)) ^ clock_phase ? (sckRise | sckFall) : 1'b0;
          shiftEdge  = (sckRise | sckFall) & ~sampleEdge;
        end
        if (txLoad)
        begin
          s_next.txFull  = 1'b0;
          s_next.txEmpty = 1'b1;
        end
      end
      else if (!master)
      begin
        s_next.state = spicc_pkg::IDLE;
      end

      if (sampleEdge)
      begin
        s_next.shifter = shiftIn(s_reg.shifter, lsbFirst, inBit); // RQ7
        s_next.bitCnt  = s_reg.bitCnt + 4'h1;
        if (s_reg.bitCnt + 4'h1 == spicc_pkg::BIT_COUNT)
        begin
          rxDone       = 1'b1;
          s_next.state = master ? spicc_pkg::TRAIL : spicc_pkg::IDLE;
        end
      end
    end

    if (rxDone)
    begin
      s_next.rxBuf  = shiftIn(s_reg.shifter, lsbFirst, inBit);
      s_next.rxFull = 1'b1;
    end

    // Mode fault: master with select pin as fault input sees it low
    if (enable && master && mode_fault_enable && !select_output_enable && selLow)
    begin
      faultNow         = 1'b1; // RQ17
      s_next.modeFault = 1'b1;
      s_next.mainCtl[spicc_pkg::ROLE_SELECT_POS] = 1'b0;
      s_next.state     = spicc_pkg::IDLE;
    end

    // Disable resets engine and buffers
    if (!enable)
    begin
      s_next.state      = spicc_pkg::IDLE; // RQ2
      s_next.txFull     = 1'b0;
      s_next.rxFull     = 1'b0;
      s_next.txEmpty    = 1'b1;
      s_next.bitCnt     = 4'h0;
      s_next.statusSeen = 1'b0;
    end

    // Sticky events: set wins over software clear
    events = {faultNow, rxDone, txLoad};
    s_next.irqSt = s_next.irqSt | events;

    // Serial clock: idle level is polarity, toggles on each half tick
    s_next.clkOut = clock_polarity ^ (s_next.state != spicc_pkg::IDLE && s_next.edgeSel != clock_phase); // RQ5
    // Data moves only on shift edges or while idle, so the sample edge sees a settled bit
    if (shiftEdge || s_reg.state == spicc_pkg::IDLE)
    begin
      s_next.mosiOut = outBit(s_next.shifter, lsbFirst); // RQ7
      s_next.misoOut = outBit(s_next.shifter, lsbFirst);
    end
    s_next.selectOut = ~(s_next.state != spicc_pkg::IDLE);
    s_next.pinsOwned = enable; // RQ15
    s_next.clkOe_n   = ~(enable & master); // RQ4
    if (master)
    begin
      s_next.mosiOe_n = ~(enable & (~single | bidir_output_enable)); // RQ12
      s_next.misoOe_n = 1'b1;
      s_next.selectOe_n = ~(enable & mode_fault_enable & select_output_enable); // RQ8
    end
    else
    begin
      s_next.mosiOe_n   = 1'b1;
      s_next.misoOe_n   = ~(enable & selLow & (~single | bidir_output_enable)); // RQ12
      s_next.selectOe_n = 1'b1; // RQ9
    end

    s_next.irq = (enable & s_next.mainCtl[spicc_pkg::RX_FAULT_IRQ_EN_POS]
                  & (s_next.rxFull | s_next.modeFault)) // RQ1
               | (enable & s_next.mainCtl[spicc_pkg::TX_EMPTY_IRQ_EN_POS] & s_next.txEmpty) // RQ3
               | (|(s_next.irqSt & s_next.irqEn));
    if (bus.wr && bus.addr == spicc_pkg::MAIN_ADDR && bus.wdata[spicc_pkg::SYSTEM_ENABLE_POS]
        && s_reg.modeFault)
    begin
      s_next.modeFault = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg            <= '0;
      s_reg.mainCtl    <= spicc_pkg::MAIN_RESET;
      s_reg.optCtl     <= spicc_pkg::OPTION_RESET;
      s_reg.baud       <= spicc_pkg::BAUD_RESET;
      s_reg.irqEn      <= spicc_pkg::IRQ_MASK_RESET;
      s_reg.txEmpty    <= 1'b1;
      s_reg.clkSync    <= 3'h0;
      s_reg.selSync    <= 3'h7;
      s_reg.clkOe_n    <= 1'b1;
      s_reg.mosiOe_n   <= 1'b1;
      s_reg.misoOe_n   <= 1'b1;
      s_reg.selectOe_n <= 1'b1;
      s_reg.selectOut  <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rdata      = s_reg.rdata;
  assign clkOut     = s_reg.clkOut;
  assign clkOe_n    = s_reg.clkOe_n;
  assign mosiOut    = s_reg.mosiOut;
  assign mosiOe_n   = s_reg.mosiOe_n;
  assign misoOut    = s_reg.misoOut;
  assign misoOe_n   = s_reg.misoOe_n;
  assign selectOut  = s_reg.selectOut;
  assign selectOe_n = s_reg.selectOe_n;
  assign pinsOwned  = s_reg.pinsOwned;
  assign irq        = s_reg.irq;
endmodule : spicc_top

// *** hdl/spicc_pkg.sv ***
// Package: register map, field positions and shared types of the serial control block
package spicc_pkg;
  localparam logic [2:0] MAIN_ADDR    = 3'h0;
  localparam logic [2:0] OPTION_ADDR  = 3'h1;
  localparam logic [2:0] BAUD_ADDR    = 3'h2;
  localparam logic [2:0] STATUS_ADDR  = 3'h3;
  localparam logic [2:0] DATA_ADDR    = 3'h4;
  localparam logic [2:0] IRQ_EN_ADDR  = 3'h5;
  localparam logic [2:0] IRQ_CLR_ADDR = 3'h6;
  localparam logic [2:0] IRQ_ST_ADDR  = 3'h7;

  localparam int RX_FAULT_IRQ_EN_POS = 7;
  localparam int SYSTEM_ENABLE_POS   = 6;
  localparam int TX_EMPTY_IRQ_EN_POS = 5;
  localparam int ROLE_SELECT_POS     = 4;
  localparam int CLOCK_POLARITY_POS  = 3;
  localparam int CLOCK_PHASE_POS     = 2;
  localparam int SELECT_OUT_EN_POS   = 1;
  localparam int BIT_ORDER_POS       = 0;
  localparam int MODE_FAULT_EN_POS   = 4;
  localparam int BIDIR_OUT_EN_POS    = 3;
  localparam int WAIT_CLOCK_STOP_POS = 1;
  localparam int SINGLE_WIRE_POS     = 0;
  localparam int RECEIVE_FULL_POS    = 7;
  localparam int MODE_FAULT_POS      = 4;
  localparam int TRANSMIT_EMPTY_POS  = 5;

  localparam logic [7:0] MAIN_RESET     = 8'h04;
  localparam logic [7:0] OPTION_RESET   = 8'h00;
  localparam logic [7:0] OPTION_MASK    = 8'h1b;
  localparam logic [7:0] BAUD_RESET     = 8'h00;
  localparam logic [7:0] BAUD_MASK      = 8'h77;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [3:0] BIT_COUNT      = 4'h8;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spicc_bus_t;

  typedef struct packed {
    logic clkIn;
    logic mosiIn;
    logic misoIn;
    logic selectIn;
  } spicc_pins_in_t;

  typedef enum logic [1:0] {IDLE, LEAD, SHIFT, TRAIL} spicc_state_t;
endpackage : spicc_pkg

// *** hdl/spicc_baud_gen.sv ***
// Baud tick generator: prescaler 1..8 followed by power-of-two divider
`timescale 1ns/1ps
module spicc_baud_gen
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] prescaleSel,
  input  wire logic [2:0] divideSel,
  output logic            halfTick
);
  typedef struct packed {
    logic [2:0] pre;
    logic [7:0] div;
    logic       tick;
  } spicc_baud_state_t;

  spicc_baud_state_t s_reg;
  spicc_baud_state_t s_next;

  // Half bit period is the full prescaler times divider, so divider select 2 gives four counts
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run)
    begin
      s_next.pre = 3'h0;
      s_next.div = 8'h00;
    end
    else if (s_reg.pre == prescaleSel)
    begin
      s_next.pre = 3'h0;
      if (s_reg.div == 8'((9'h001 << divideSel) - 9'h001))
      begin
        s_next.div  = 8'h00;
        s_next.tick = 1'b1; // RQ16
      end
      else
      begin
        s_next.div = s_reg.div + 8'h01;
      end
    end
    else
    begin
      s_next.pre = s_reg.pre + 3'h1; // RQ16
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign halfTick = s_reg.tick;
endmodule : spicc_baud_gen

// *** sim/spicc_properties.sv ***
// Checker: port-level properties of the serial control block
`timescale 1ns/1ps
module spicc_properties
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire spicc_pkg::spicc_bus_t bus,
  input wire logic [7:0]            rdata,
  input wire logic                  clkOe_n,
  input wire logic                  mosiOe_n,
  input wire logic                  misoOe_n,
  input wire logic                  selectOe_n,
  input wire logic                  pinsOwned,
  input wire logic                  irq
);
  logic [7:0] mainSh;
  logic [7:0] optSh;
  logic [1:0] quietCnt;
  // Shadow of the control bits; judged only once outputs had time to follow
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mainSh   <= spicc_pkg::MAIN_RESET;
      optSh    <= spicc_pkg::OPTION_RESET;
      quietCnt <= 2'h0;
    end
    else if (bus.wr && bus.addr == spicc_pkg::MAIN_ADDR)
    begin
      mainSh   <= bus.wdata;
      quietCnt <= 2'h0;
    end
    else if (bus.wr && bus.addr == spicc_pkg::OPTION_ADDR)
    begin
      optSh    <= bus.wdata;
      quietCnt <= 2'h0;
    end
    else if (quietCnt != 2'h3)
      quietCnt <= quietCnt + 2'h1;
  end
  wire settled = quietCnt == 2'h3;
  wire en      = mainSh[spicc_pkg::SYSTEM_ENABLE_POS];
  wire master  = mainSh[spicc_pkg::ROLE_SELECT_POS];
  wire faultEn = optSh[spicc_pkg::MODE_FAULT_EN_POS];
  wire selOut  = mainSh[spicc_pkg::SELECT_OUT_EN_POS];
  wire single  = optSh[spicc_pkg::SINGLE_WIRE_POS];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_option_gaps_zero: assert property (bus.rd && bus.addr == spicc_pkg::OPTION_ADDR |=>
    (rdata & ~spicc_pkg::OPTION_MASK) == 8'h00) else $error("unimplemented option bits read nonzero");
  a_disabled_pins_free: assert property (settled && !en |-> !pinsOwned && clkOe_n && mosiOe_n
    && misoOe_n && selectOe_n) else $error("pins driven while disabled");
  a_enabled_pins_owned: assert property (settled && en |-> pinsOwned)
    else $error("pins not owned while enabled");
  a_slave_pins_input: assert property (settled && en && !master |-> clkOe_n && selectOe_n && mosiOe_n)
    else $error("slave drives clock, select or master-out pin");
  a_master_drives_clk: assert property (settled && en && master && (!faultEn || selOut) |->
    !clkOe_n && misoOe_n && (single || !mosiOe_n)) else $error("master pin directions wrong");
  a_select_gpio_free: assert property (settled && en && master && !faultEn |-> selectOe_n)
    else $error("select pin driven with mode fault off");
  a_select_auto_out: assert property (settled && en && master && faultEn && selOut |-> !selectOe_n)
    else $error("automatic select output not driven");
  a_bidir_master_oe: assert property (settled && en && master && !faultEn && single |->
    mosiOe_n == !optSh[spicc_pkg::BIDIR_OUT_EN_POS]) else $error("shared data pin direction wrong");
  c_irq_raised: cover property ($rose(irq));
  c_master_active: cover property (settled && en && master && !clkOe_n);
  c_slave_shared_out: cover property (settled && en && !master && single && !misoOe_n);
endmodule : spicc_properties

bind spicc_top spicc_properties u_props (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .clkOe_n(clkOe_n),
  .mosiOe_n(mosiOe_n), .misoOe_n(misoOe_n), .selectOe_n(selectOe_n), .pinsOwned(pinsOwned), .irq(irq));

// *** sim/spicc_peer_model.sv ***
// Partner: behavioural serial peer exchanging one byte per load pulse
`timescale 1ns/1ps
module spicc_peer_model
(
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic [7:0] cfg,
  input  wire logic       load,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  int   n = 8;
  logic lead;
  function automatic logic pick(input int i);
    return cfg[spicc_pkg::BIT_ORDER_POS] ? txByte[i] : txByte[7 - i];
  endfunction : pick
  initial miso = 1'b0;
  always @(posedge load)
  begin
    n = 0;
    miso = pick(0);
  end
  // Outside a byte the line toggles, so a held last bit never passes as data
  always @(sclk)
  begin
    lead = sclk != cfg[spicc_pkg::CLOCK_POLARITY_POS];
    if (n < 8 && lead != cfg[spicc_pkg::CLOCK_PHASE_POS])
    begin
      rxByte[cfg[spicc_pkg::BIT_ORDER_POS] ? n : 7 - n] = mosi;
      n++;
    end
    else if (n < 8 && (n > 0 || cfg[spicc_pkg::CLOCK_PHASE_POS]))
      miso = pick(n);
    else
      miso = ~miso;
  end
endmodule : spicc_peer_model

// *** sim/tb_spi_control_config.sv ***
// Testbench: registers, transfers, interrupts and pin directions of the serial control block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_spi_control_config;
  typedef struct packed {logic [2:0] addr; logic [7:0] wdata; logic doWr; logic [7:0] expRd;} spicc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic waitMode = 1'b0;
  logic selLevel = 1'b1;
  logic peerLoad = 1'b0;
  logic [7:0] peerTx = 8'h00;
  logic [7:0] sent;
  logic [7:0] cfg = 8'h04;
  logic [7:0] v;
  logic [7:0] m;
  logic [7:0] rdata;
  logic [7:0] peerRx;
  logic peerMiso, clkOut, clkOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n, selectOut, selectOe_n, pinsOwned, irq;
  int failCount = 0;
  int checked = 0;
  spicc_pkg::spicc_bus_t bus = '0;
  spicc_pkg::spicc_pins_in_t pinsIn;
  // Undriven clock and master-out lines are pulled low; an undriven master-in line follows the peer
  assign pinsIn = {clkOe_n ? 1'b0 : clkOut, mosiOe_n ? 1'b0 : mosiOut, misoOe_n ? peerMiso : misoOut,
                   selectOe_n ? selLevel : selectOut};
  spicc_top dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .waitMode(waitMode), .pins(pinsIn),
    .clkOut(clkOut), .clkOe_n(clkOe_n), .mosiOut(mosiOut), .mosiOe_n(mosiOe_n), .misoOut(misoOut),
    .misoOe_n(misoOe_n), .selectOut(selectOut), .selectOe_n(selectOe_n), .pinsOwned(pinsOwned), .irq(irq));
  spicc_peer_model peer (.sclk(pinsIn.clkIn), .mosi(pinsIn.mosiIn), .cfg(cfg), .load(peerLoad),
    .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));
  spicc_row_t rows [13] = '{
    '{spicc_pkg::MAIN_ADDR, 8'h00, 1'b0, 8'h04}, '{spicc_pkg::OPTION_ADDR, 8'h00, 1'b0, 8'h00},
    '{spicc_pkg::BAUD_ADDR, 8'h00, 1'b0, 8'h00}, '{spicc_pkg::STATUS_ADDR, 8'h00, 1'b0, 8'h20},
    '{spicc_pkg::IRQ_EN_ADDR, 8'h00, 1'b0, 8'h00}, '{spicc_pkg::IRQ_ST_ADDR, 8'h00, 1'b0, 8'h00},
    '{spicc_pkg::OPTION_ADDR, 8'hff, 1'b1, 8'h1b}, '{spicc_pkg::OPTION_ADDR, 8'h00, 1'b1, 8'h00},
    '{spicc_pkg::MAIN_ADDR, 8'hbf, 1'b1, 8'hbf}, '{spicc_pkg::MAIN_ADDR, 8'h04, 1'b1, 8'h04},
    '{spicc_pkg::BAUD_ADDR, 8'hff, 1'b1, 8'h77}, '{spicc_pkg::STATUS_ADDR, 8'hff, 1'b1, 8'h20},
    '{spicc_pkg::IRQ_EN_ADDR, 8'h00, 1'b1, 8'h00}};
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    @(negedge clk) v = rdata;
  endtask : rd
  task automatic start(input logic [7:0] d, input logic [7:0] p);
    peerTx = p;
    sent = d;
    @(posedge clk) peerLoad <= 1'b1;
    @(posedge clk) peerLoad <= 1'b0;
    rd(spicc_pkg::STATUS_ADDR);
    `CHK(v[spicc_pkg::TRANSMIT_EMPTY_POS], 1'b1)
    `CHK(irq, 1'b0)
    wr(spicc_pkg::DATA_ADDR, d);
  endtask : start
  task automatic finish();
    v = 8'h00;
    for (int k = 0; k < 60 && !v[spicc_pkg::RECEIVE_FULL_POS]; k++)
      rd(spicc_pkg::STATUS_ADDR);
    `CHK(v[spicc_pkg::RECEIVE_FULL_POS], 1'b1)
    `CHK(irq, cfg[7])
    rd(spicc_pkg::DATA_ADDR);
    `CHK(v, peerTx)
    `CHK(peerRx, sent)
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
  endtask : finish
  task automatic settle(input logic [2:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (4) @(posedge clk);
  endtask : settle
  task automatic testDone();
    if (failCount == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : testDone
  initial
  begin
    repeat (10000) @(posedge clk);
    failCount++;
    testDone();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k])
    begin
      if (rows[k].doWr)
        wr(rows[k].addr, rows[k].wdata);
      rd(rows[k].addr);
      `CHK(v, rows[k].expRd)
    end
    wr(spicc_pkg::BAUD_ADDR, 8'h02);
    for (int i = 0; i < 8; i++)
    begin
      m = {4'hd, i[0], i[1], i[2], i[2]};
      wr(spicc_pkg::MAIN_ADDR, cfg & 8'hbf);
      wr(spicc_pkg::OPTION_ADDR, {3'h0, i[2], 4'h0});
      wr(spicc_pkg::MAIN_ADDR, m & 8'hbf);
      cfg = m;
      waitMode <= i[0];
      settle(spicc_pkg::MAIN_ADDR, m);
      `CHK(clkOut, m[3])
      start(8'h1d ^ 8'(i), 8'hb4 ^ 8'(i << 4));
      finish();
    end
    settle(spicc_pkg::MAIN_ADDR, 8'hff);
    `CHK(irq, 1'b1)
    settle(spicc_pkg::MAIN_ADDR, 8'h5f);
    `CHK(irq, 1'b0)
    cfg = 8'h5f;
    settle(spicc_pkg::IRQ_EN_ADDR, 8'h02);
    `CHK(irq, 1'b1)
    settle(spicc_pkg::IRQ_EN_ADDR, 8'h00);
    `CHK(irq, 1'b0)
    wr(spicc_pkg::IRQ_CLR_ADDR, 8'h07);
    rd(spicc_pkg::IRQ_ST_ADDR);
    `CHK(v, 8'h00)
    wr(spicc_pkg::OPTION_ADDR, 8'h02);
    waitMode <= 1'b1;
    start(8'h3c, 8'h81);
    repeat (200) @(posedge clk);
    rd(spicc_pkg::STATUS_ADDR);
    `CHK(v[spicc_pkg::RECEIVE_FULL_POS], 1'b0)
    @(posedge clk) waitMode <= 1'b0;
    finish();
    wr(spicc_pkg::OPTION_ADDR, 8'h00);
    wr(spicc_pkg::BAUD_ADDR, 8'h03);
    start(8'h5a, 8'ha5);
    repeat (30) @(posedge clk);
    wr(spicc_pkg::MAIN_ADDR, 8'h1f);
    rd(spicc_pkg::STATUS_ADDR);
    `CHK(v, 8'h20)
    `CHK(pinsOwned, 1'b0)
    `CHK(clkOe_n, 1'b1)
    wr(spicc_pkg::OPTION_ADDR, 8'h10);
    wr(spicc_pkg::MAIN_ADDR, 8'h94);
    wr(spicc_pkg::MAIN_ADDR, 8'hd4);
    cfg = 8'hd4;
    @(posedge clk) selLevel <= 1'b0;
    repeat (6) @(posedge clk);
    rd(spicc_pkg::STATUS_ADDR);
    `CHK(v[spicc_pkg::MODE_FAULT_POS], 1'b1)
    `CHK(irq, 1'b1)
    rd(spicc_pkg::MAIN_ADDR);
    `CHK(v[spicc_pkg::ROLE_SELECT_POS], 1'b0)
    wr(spicc_pkg::MAIN_ADDR, 8'h44);
    settle(spicc_pkg::OPTION_ADDR, 8'h19);
    `CHK(misoOe_n, 1'b0)
    `CHK(selectOe_n, 1'b1)
    settle(spicc_pkg::OPTION_ADDR, 8'h11);
    `CHK(misoOe_n, 1'b1)
    wr(spicc_pkg::OPTION_ADDR, 8'h09);
    settle(spicc_pkg::MAIN_ADDR, 8'h54);
    `CHK(mosiOe_n, 1'b0)
    `CHK(misoOe_n, 1'b1)
    settle(spicc_pkg::OPTION_ADDR, 8'h01);
    `CHK(mosiOe_n, 1'b1)
    testDone();
  end
endmodule : tb_spi_control_config
